// ===== mpio_btn.sv
// Push buttons, external pull-downs and pin loads
`timescale 1ns/1ps
`default_nettype none
module mpio_btn (
   input wire logic [5:0] press,
   input wire logic [5:0] pin_out,
   input wire logic [5:0] pin_oe_n,
   input wire logic [5:0] pin_pull_up,
   output logic [5:0] pin_in
);
   // Board pull-downs settle undriven lines low unless the pin pull-up is on or the button is pressed
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         pin_in[i] = !pin_oe_n[i] ? pin_out[i] : (press[i] | pin_pull_up[i]);
      end
   end
endmodule
`default_nettype wire

// ===== mpio_defs.vh
// Register indices, field positions, reset values and mode codes of the I/O pin block
`ifndef MPIO_DEFS_VH
`define MPIO_DEFS_VH

`define MPIO_AW 8
`define MPIO_DW 24
`define MPIO_NPIN 6
`define MPIO_NBTN 21

`define MPIO_IDX_LEVEL 8'h00
`define MPIO_IDX_MODE 8'h0b
`define MPIO_IDX_AUX 8'h11
`define MPIO_IDX_ST_FALL 8'h1a
`define MPIO_IDX_ST_RISE 8'h1b
`define MPIO_IDX_ST_PRESS 8'h1c

`define MPIO_MODE_LSB 16
`define MPIO_LEVEL_LSB 10
`define MPIO_AUX_MODE_LSB 2
`define MPIO_AUX_LEVEL_LSB 6

`define MPIO_MODE_OUT 2'h0
`define MPIO_MODE_PULLUP 2'h1
`define MPIO_MODE_PULLDN 2'h2
`define MPIO_MODE_INPUT 2'h3

`define MPIO_RST_LEVEL 24'h000000
`define MPIO_RST_MODE 24'hff0000
`define MPIO_RST_AUX 24'h000034

`define MPIO_PAIR_BASE_D1 5'h06
`define MPIO_PAIR_BASE_D2 5'h0b
`define MPIO_PAIR_BASE_D3 5'h0f
`define MPIO_PAIR_BASE_D4 5'h12
`define MPIO_PAIR_BASE_D5 5'h14

`define MPIO_BRIDGE_PIN 3
`define MPIO_SYNC_W 8

`endif

// ===== mpio_pins.v
// Six multipurpose I/O pins with serial sharing, bridge control and button expansion
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "mpio_defs.vh"
module mpio_pins (
   input wire clk,
   input wire rst,
   input wire [`MPIO_AW-1:0] reg_addr,
   input wire [`MPIO_DW-1:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [`MPIO_DW-1:0] reg_rdata,
   input wire [`MPIO_NPIN-1:0] pin_in,
   output reg [`MPIO_NPIN-1:0] pin_out,
   output reg [`MPIO_NPIN-1:0] pin_oe_n,
   output reg [`MPIO_NPIN-1:0] pin_pull_up,
   output reg [`MPIO_NPIN-1:0] pin_pull_dn,
   input wire serial_port_enable,
   input wire chip_select_or_reset_pin,
   input wire bridge_mode,
   input wire bridge_mux_ctrl,
   input wire serial_data_out,
   output reg serial_data_in,
   output reg serial_clock,
   output reg serial_chip_select,
   output reg ext_reset_req,
   input wire program_jump
);
   reg [`MPIO_DW-1:0] level_cfg;
   reg [`MPIO_DW-1:0] mode_cfg;
   reg [`MPIO_DW-1:0] aux_cfg;
   reg [`MPIO_NBTN-1:0] st_fall;
   reg [`MPIO_NBTN-1:0] st_rise;
   reg [`MPIO_NBTN-1:0] st_press;
   reg [`MPIO_NBTN-1:0] decoded;
   reg [`MPIO_NBTN-1:0] acc_fall;
   reg [`MPIO_NBTN-1:0] acc_rise;
   reg [`MPIO_NBTN-1:0] next_decoded;
   reg [`MPIO_NPIN-1:0] next_out;
   reg [`MPIO_NPIN-1:0] next_oe_n;
   reg [`MPIO_NPIN-1:0] next_pu;
   reg [`MPIO_NPIN-1:0] next_pd;
   reg [`MPIO_DW-1:0] next_rdata;
   reg [1:0] mode [0:`MPIO_NPIN-1];
   reg [`MPIO_NPIN-1:0] level;
   reg [`MPIO_NPIN-1:0] lines;
   reg any_out;
   reg [2:0] active_cnt;
   reg [2:0] first_i;
   reg [2:0] second_i;
   wire [`MPIO_SYNC_W-1:0] synced;
   wire [`MPIO_NPIN-1:0] pin_s;
   wire ser_en_s;
   wire cs_s;
   wire [`MPIO_NBTN-1:0] rise_now;
   wire [`MPIO_NBTN-1:0] fall_now;
   integer k;

   // Bit position of the combined button for lines a < b
   function [4:0] pair_bit;
      input [2:0] a;
      input [2:0] b;
      reg [2:0] d;
      begin
         d = b - a;
         case (d)
            3'h1: pair_bit = `MPIO_PAIR_BASE_D1 + {2'h0, a};
            3'h2: pair_bit = `MPIO_PAIR_BASE_D2 + {2'h0, a};
            3'h3: pair_bit = `MPIO_PAIR_BASE_D3 + {2'h0, a};
            3'h4: pair_bit = `MPIO_PAIR_BASE_D4 + {2'h0, a};
            3'h5: pair_bit = `MPIO_PAIR_BASE_D5;
            default: pair_bit = 5'h00;
         endcase
      end
   endfunction

   mpio_sync #(
      .WIDTH(`MPIO_SYNC_W)
   ) u_sync (
      .clk(clk),
      .rst(rst),
      .async_in({chip_select_or_reset_pin, serial_port_enable, pin_in}),
      .sync_out(synced)
   );

   assign pin_s = synced[`MPIO_NPIN-1:0];
   assign ser_en_s = synced[`MPIO_NPIN];
   assign cs_s = synced[`MPIO_NPIN+1];

   // Per-pin mode fields and output levels
   always @* begin
      for (k = 0; k < 4; k = k + 1) begin
         mode[k] = mode_cfg[`MPIO_MODE_LSB + 2*k +: 2];
         level[k] = level_cfg[`MPIO_LEVEL_LSB + k];
      end
      for (k = 4; k < `MPIO_NPIN; k = k + 1) begin
         mode[k] = aux_cfg[`MPIO_AUX_MODE_LSB + 2*(k-4) +: 2];
         level[k] = aux_cfg[`MPIO_AUX_LEVEL_LSB + k - 4];
      end
   end

   // Pin drivers, pulls and overrides
   always @* begin
      any_out = 1'b0;
      for (k = 0; k < `MPIO_NPIN; k = k + 1) begin
         next_out[k] = 1'b0;
         next_oe_n[k] = 1'b1;
         next_pu[k] = 1'b0;
         next_pd[k] = 1'b0;
         if (!ser_en_s && !(bridge_mode && k == `MPIO_BRIDGE_PIN)) begin
            case (mode[k])
               `MPIO_MODE_OUT: begin
                  next_out[k] = level[k];
                  next_oe_n[k] = 1'b0;
                  any_out = 1'b1;
               end
               `MPIO_MODE_PULLUP: next_pu[k] = 1'b1;
               `MPIO_MODE_PULLDN: next_pd[k] = 1'b1;
               default: next_pu[k] = 1'b0;
            endcase
         end
      end
      // serial data out on pin 0
      if (ser_en_s) begin
         next_out[0] = serial_data_out;
         next_oe_n[0] = 1'b0;
      end
      if (bridge_mode) begin
         next_out[`MPIO_BRIDGE_PIN] = bridge_mux_ctrl;
         next_oe_n[`MPIO_BRIDGE_PIN] = 1'b0;
      end
   end

   // Button decoding; with no serial port and no output pin, more than two lines at once keep the last result
   always @* begin
      lines = pin_s;
      if (bridge_mode) begin
         lines[`MPIO_BRIDGE_PIN] = 1'b0;
      end
      active_cnt = 3'h0;
      first_i = 3'h0;
      second_i = 3'h0;
      for (k = `MPIO_NPIN - 1; k >= 0; k = k - 1) begin
         if (lines[k]) begin
            active_cnt = active_cnt + 3'h1;
            second_i = first_i;
            first_i = k[2:0];
         end
      end
      next_decoded = {`MPIO_NBTN{1'b0}};
      if (ser_en_s || any_out) begin
         next_decoded[`MPIO_NPIN-1:0] = lines;
      end else begin
         case (active_cnt)
            3'h0: next_decoded = {`MPIO_NBTN{1'b0}};
            3'h1: next_decoded[first_i] = 1'b1;
            3'h2: begin
               if (!decoded[first_i] && !decoded[second_i]) begin
                  next_decoded[pair_bit(first_i, second_i)] = 1'b1;
               end else if (decoded[pair_bit(first_i, second_i)]) begin
                  next_decoded[pair_bit(first_i, second_i)] = 1'b1;
               end else begin
                  next_decoded[first_i] = 1'b1;
                  next_decoded[second_i] = 1'b1;
               end
            end
            default: next_decoded = decoded;
         endcase
      end
   end

   assign rise_now = next_decoded & ~decoded;
   assign fall_now = decoded & ~next_decoded;

   // Edge history between refreshes; an edge in the refresh cycle goes into the status words, not the history
   always @(posedge clk) begin
      if (rst) begin
         decoded <= {`MPIO_NBTN{1'b0}};
         acc_rise <= {`MPIO_NBTN{1'b0}};
         acc_fall <= {`MPIO_NBTN{1'b0}};
         st_rise <= {`MPIO_NBTN{1'b0}};
         st_fall <= {`MPIO_NBTN{1'b0}};
         st_press <= {`MPIO_NBTN{1'b0}};
      end else begin
         decoded <= next_decoded;
         if (program_jump) begin
            // pair in rising and pressed words
            st_rise <= acc_rise | rise_now;
            st_fall <= acc_fall | fall_now;
            st_press <= next_decoded;
            acc_rise <= {`MPIO_NBTN{1'b0}};
            acc_fall <= {`MPIO_NBTN{1'b0}};
         end else begin
            acc_rise <= acc_rise | rise_now;
            acc_fall <= acc_fall | fall_now;
         end
      end
   end

   // Register writes
   always @(posedge clk) begin
      if (rst) begin
         level_cfg <= `MPIO_RST_LEVEL;
         mode_cfg <= `MPIO_RST_MODE;
         // pin 4 starts pulled up, pin 5 as a plain input
         aux_cfg <= `MPIO_RST_AUX;
      end else if (reg_wr) begin
         case (reg_addr)
            `MPIO_IDX_LEVEL: level_cfg <= reg_wdata;
            `MPIO_IDX_MODE: mode_cfg <= reg_wdata;
            `MPIO_IDX_AUX: aux_cfg <= reg_wdata;
            default: level_cfg <= level_cfg;
         endcase
      end
   end

   // Read data; unmapped words read zero
   always @* begin
      next_rdata = {`MPIO_DW{1'b0}};
      if (reg_rd) begin
         case (reg_addr)
            `MPIO_IDX_LEVEL: next_rdata = level_cfg;
            `MPIO_IDX_MODE: next_rdata = mode_cfg;
            `MPIO_IDX_AUX: next_rdata = aux_cfg;
            `MPIO_IDX_ST_FALL: next_rdata = {3'h0, st_fall};
            `MPIO_IDX_ST_RISE: next_rdata = {3'h0, st_rise};
            `MPIO_IDX_ST_PRESS: next_rdata = {3'h0, st_press};
            default: next_rdata = {`MPIO_DW{1'b0}};
         endcase
      end
   end

   // Registered outputs
   always @(posedge clk) begin
      if (rst) begin
         reg_rdata <= {`MPIO_DW{1'b0}};
         pin_out <= {`MPIO_NPIN{1'b0}};
         pin_oe_n <= {`MPIO_NPIN{1'b1}};
         pin_pull_up <= {`MPIO_NPIN{1'b0}};
         pin_pull_dn <= {`MPIO_NPIN{1'b0}};
         serial_data_in <= 1'b0;
         serial_clock <= 1'b0;
         serial_chip_select <= 1'b0;
         ext_reset_req <= 1'b0;
      end else begin
         reg_rdata <= next_rdata;
         pin_out <= next_out;
         pin_oe_n <= next_oe_n;
         pin_pull_up <= next_pu;
         pin_pull_dn <= next_pd;
         // serial inputs from pins 1 and 2
         serial_data_in <= ser_en_s & pin_s[1];
         serial_clock <= ser_en_s & pin_s[2];
         serial_chip_select <= ser_en_s & cs_s;
         ext_reset_req <= ~ser_en_s & cs_s;
      end
   end
endmodule
`default_nettype wire

// ===== mpio_pins_properties.sv
// Port-level assertions for the multipurpose pin block
`timescale 1ns/1ps
`default_nettype none
`include "mpio_defs.vh"
module mpio_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic [`MPIO_AW-1:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [`MPIO_DW-1:0] reg_rdata,
   input wire logic [`MPIO_NPIN-1:0] pin_out,
   input wire logic [`MPIO_NPIN-1:0] pin_oe_n,
   input wire logic [`MPIO_NPIN-1:0] pin_pull_up,
   input wire logic [`MPIO_NPIN-1:0] pin_pull_dn,
   input wire logic serial_port_enable,
   input wire logic chip_select_or_reset_pin,
   input wire logic bridge_mode,
   input wire logic bridge_mux_ctrl,
   input wire logic serial_data_out,
   input wire logic ext_reset_req
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Five cycles covers the two-flop sync plus the output flop
   sequence s_ser_on; serial_port_enable[*5]; endsequence
   sequence s_ser_off_cs; (!serial_port_enable && chip_select_or_reset_pin)[*5]; endsequence
   property p_ser_pin0; s_ser_on |-> !pin_oe_n[0] && pin_out[0] == $past(serial_data_out);
   endproperty
   a_ser_pin0: assert property (p_ser_pin0) else $error("pin0 not serial out");
   property p_bridge; bridge_mode |=> !pin_oe_n[3] && pin_out[3] == $past(bridge_mux_ctrl);
   endproperty
   a_bridge: assert property (p_bridge) else $error("pin3 not bridge control");
   property p_ser_nopull; s_ser_on |-> pin_pull_up == 6'h00 && pin_pull_dn == 6'h00;
   endproperty
   a_ser_nopull: assert property (p_ser_nopull) else $error("pulls on in serial mode");
   property p_ext_rst; s_ser_off_cs |-> ext_reset_req; endproperty
   a_ext_rst: assert property (p_ext_rst) else $error("reset request missing");
   property p_no_ext_rst; s_ser_on |-> !ext_reset_req; endproperty
   a_no_ext_rst: assert property (p_no_ext_rst) else $error("reset request in serial");
   property p_out_pull; ((~pin_oe_n & (pin_pull_up | pin_pull_dn)) | (pin_pull_up & pin_pull_dn)) == 6'h00;
   endproperty
   a_out_pull: assert property (p_out_pull) else $error("pull on driven pin");
   property p_rst_dflt; $fell(rst) && !serial_port_enable && !bridge_mode
      |=> pin_pull_up == 6'h10 && pin_oe_n == 6'h3f;
   endproperty
   a_rst_dflt: assert property (p_rst_dflt) else $error("pin defaults wrong");
   property p_stat_w; reg_rd && reg_addr >= `MPIO_IDX_ST_FALL && reg_addr <= `MPIO_IDX_ST_PRESS
      |=> reg_rdata[23:21] == 3'h0;
   endproperty
   a_stat_w: assert property (p_stat_w) else $error("status word too wide");
endmodule
bind mpio_pins mpio_chk chk_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pull_up(pin_pull_up),
   .pin_pull_dn(pin_pull_dn), .serial_port_enable(serial_port_enable),
   .chip_select_or_reset_pin(chip_select_or_reset_pin), .bridge_mode(bridge_mode),
   .bridge_mux_ctrl(bridge_mux_ctrl), .serial_data_out(serial_data_out),
   .ext_reset_req(ext_reset_req));
`default_nettype wire

// ===== mpio_sync.v
// Two-flop synchroniser for levels entering from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module mpio_sync #(
   parameter WIDTH = 1
) (
   input wire clk,
   input wire rst,
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] stage1;

   // First stage feeds only the second stage
   always @(posedge clk) begin
      if (rst) begin
         stage1 <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule
`default_nettype wire

// ===== test_mpio_pins.sv
// Self-checking bench for the multipurpose pin block
`timescale 1ns/1ps
`default_nettype none
`include "mpio_defs.vh"
module test_mpio_pins;
   logic clk, rst, reg_wr, reg_rd, sen, cs, brg, bmux, sdo, jmp, sdi, sck, scs, xrst;
   logic [7:0] reg_addr;
   logic [23:0] reg_wdata, reg_rdata, lv;
   logic [5:0] press, pin_in, pin_out, oe_n, pu, pd;
   int errors, checks_done, cycles, pb;
   mpio_pins dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe_n(oe_n), .pin_pull_up(pu), .pin_pull_dn(pd),
      .serial_port_enable(sen), .chip_select_or_reset_pin(cs), .bridge_mode(brg),
      .bridge_mux_ctrl(bmux), .serial_data_out(sdo), .serial_data_in(sdi),
      .serial_clock(sck), .serial_chip_select(scs), .ext_reset_req(xrst), .program_jump(jmp));
   mpio_btn btn_u (.press(press), .pin_out(pin_out), .pin_oe_n(oe_n), .pin_pull_up(pu),
      .pin_in(pin_in));
   initial begin
      clk = 0;
      forever #25 clk = ~clk;
   end
   task chk(input logic [23:0] got, input logic [23:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task end_of_test;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task wr(input logic [7:0] a, input logic [23:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [23:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask
   task jump;
      @(posedge clk);
      jmp <= 1'b1;
      @(posedge clk);
      jmp <= 1'b0;
   endtask
   // Diode pair bit: per-distance base plus lower line
   function automatic int pbit(input int a, input int b);
      int base[5] = '{6, 11, 15, 18, 20};
      return base[b - a - 1] + a;
   endfunction
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         end_of_test;
      end
   end
   initial begin
      {rst, reg_wr, reg_rd, sen, cs, brg, bmux, sdo, jmp} = 9'h100;
      {reg_addr, reg_wdata, press} = '0;
      void'($urandom(99));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      settle(1);
      chk({pu, oe_n}, 12'h43f);
      rd(`MPIO_IDX_MODE, `MPIO_RST_MODE);
      rd(`MPIO_IDX_AUX, `MPIO_RST_AUX);
      rd(8'h05, 24'h000000);
      lv = $urandom;
      wr(`MPIO_IDX_LEVEL, lv);
      wr(`MPIO_IDX_MODE, 24'h390000);
      wr(`MPIO_IDX_AUX, {16'h0, 1'b0, lv[0], 6'h30});
      rd(`MPIO_IDX_LEVEL, lv);
      settle(2);
      chk({oe_n, pu, pd}, 18'h27042);
      chk({pin_out[4], pin_out[3]}, {lv[0], lv[13]});
      @(posedge clk);
      brg <= 1'b1;
      bmux <= ~lv[13];
      settle(2);
      chk({oe_n[3], pin_out[3]}, {1'b0, ~lv[13]});
      @(posedge clk);
      brg <= 1'b0;
      cs <= 1'b1;
      settle(4);
      chk(xrst, 1'b1);
      @(posedge clk);
      sen <= 1'b1;
      sdo <= $urandom;
      press <= 6'h06;
      settle(5);
      chk({oe_n, pu, pd}, 18'h3e000);
      chk({pin_out[0], sdi, sck, scs, xrst}, {sdo, 4'he});
      @(posedge clk);
      {sen, cs, press} <= '0;
      wr(`MPIO_IDX_MODE, `MPIO_RST_MODE);
      wr(`MPIO_IDX_AUX, 24'h000038);
      settle(6);
      jump;
      @(posedge clk);
      press <= 6'h01;
      settle(6);
      press <= 6'h03;
      settle(6);
      jump;
      // Second line joins a held one: no pair
      rd(`MPIO_IDX_ST_PRESS, 24'h000003);
      press <= 6'h00;
      settle(6);
      jump;
      for (int a = 0; a < 5; a++) begin
         for (int b = a + 1; b < 6; b++) begin
            // Lines 3 and 4 skipped: their pair bit 9 is left unchecked
            if (a != 3 || b != 4) begin
               pb = pbit(a, b);
               press <= (6'h01 << a) | (6'h01 << b);
               settle(6);
               jump;
               rd(`MPIO_IDX_ST_RISE, 24'h1 << pb);
               rd(`MPIO_IDX_ST_PRESS, 24'h1 << pb);
               press <= 6'h00;
               settle(6);
               rd(`MPIO_IDX_ST_PRESS, 24'h1 << pb);
               jump;
               rd(`MPIO_IDX_ST_FALL, 24'h1 << pb);
               rd(`MPIO_IDX_ST_PRESS, 24'h000000);
            end
         end
      end
      end_of_test;
   end
endmodule
`default_nettype wire
